// ===== logic/tcs_pin_sync.sv
`timescale 1ns/1ps
module tcs_pin_sync
  import tcs_pkg::*;
(
  // clock and reset
  input  wire logic              ref_clk_i,
  input  wire logic              rst_i,
  // raw pins and filtered levels
  input  wire logic [SYNC_W-1:0] raw_i,
  output logic      [SYNC_W-1:0] level_o
);
  logic [SYNC_W-1:0] meta_ff;
  logic [SYNC_W-1:0] s2_ff;
  logic [SYNC_W-1:0] s3_ff;
  logic [SYNC_W-1:0] level_ff;
  logic [SYNC_W-1:0] nxt_level;

  // a change counts once the second and third stages agree
  always_comb begin
    for (int i = 0; i < SYNC_W; i++) begin
      nxt_level[i] = (s2_ff[i] == s3_ff[i]) ? s3_ff[i] : level_ff[i];
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      meta_ff  <= SYNC_RST;
      s2_ff    <= SYNC_RST;
      s3_ff    <= SYNC_RST;
      level_ff <= SYNC_RST;
    end else begin
      meta_ff  <= raw_i;
      s2_ff    <= meta_ff;
      s3_ff    <= s2_ff;
      level_ff <= nxt_level;
    end
  end

  assign level_o = level_ff;
endmodule

// ===== logic/tcs_pkg.sv
package tcs_pkg;
  // clock and machine cycle
  localparam int unsigned REF_CLK_HZ     = 100_000_000;
  localparam int unsigned REF_PERIOD_NS  = 10;
  localparam int unsigned MCYC_REF_CYC   = 2;
  localparam int unsigned MCYC_HALF_CYC  = MCYC_REF_CYC / 2;
  localparam int unsigned PHASE_W        = 1;
  localparam logic [PHASE_W-1:0] PHASE_FIRST = 1'h0;
  localparam logic [PHASE_W-1:0] PHASE_LAST  = PHASE_W'(MCYC_REF_CYC - 1);
  localparam logic [PHASE_W-1:0] PHASE_HALF  = PHASE_W'(MCYC_HALF_CYC);
  localparam logic [PHASE_W-1:0] PHASE_STEP  = 1'h1;

  // clock mode strap
  localparam int unsigned STRAP_W        = 3;
  localparam logic [STRAP_W-1:0] CLK_MODE_RST = 3'h0;

  // pin synchroniser layout
  localparam int unsigned SYNC_W         = 5;
  localparam int unsigned SYNC_STRAP_LSB = 0;
  localparam int unsigned SYNC_RESET_BIT = 3;
  localparam int unsigned SYNC_FLOAT_BIT = 4;
  localparam logic [SYNC_W-1:0] SYNC_RST = 5'h18;

  // one output pin: level and output enable
  typedef struct packed {
    logic lvl;
    logic oe;
  } tcs_pin_t;

  localparam tcs_pin_t PIN_RST = '{lvl: 1'b0, oe: 1'b0};

  // strap pins as they arrive
  typedef struct packed {
    logic bit3;
    logic bit2;
    logic bit1;
  } tcs_strap_t;

  typedef enum logic [0:0] {
    ST_IN_RESET,
    ST_RUN
  } tcs_state_t;
endpackage

// ===== logic/tcs_timer_out.sv
`timescale 1ns/1ps
// Behaviour
// [R1] while device reset is low, clock mode register follows the three strap pins
// [R2] after reset software may rewrite clock mode; strap changes ignored until reset
// [R3] timer zero underflow produces a pulse on the timer zero output
// [R4] timer zero pulse lasts exactly one machine clock cycle
// [R5] timer one underflow produces a pulse exactly one machine cycle wide
// [R6] timer one shares pin with host interrupt; drives only when host port disabled
// [R7] both timer outputs float while the emulation float control is low
// [R8] machine clock output runs at machine cycle rate, cycles bounded by rising edges
// [R9] underflow strobes are registered on the reference clock and released at machine cycle starts for glitch-free pulses
module tcs_timer_out
  import tcs_pkg::*;
(
  // clock and power-on reset
  input  wire logic                ref_clk_i,
  input  wire logic                rst_i,
  // device pins in
  input  wire tcs_pkg::tcs_strap_t clock_strap_i,
  input  wire logic                dev_reset_n_i,
  input  wire logic                emu_float_ctl_n_i,
  // core side
  input  wire logic                tmr0_underflow_i,
  input  wire logic                tmr1_underflow_i,
  input  wire logic                host_port_en_i,
  input  wire logic                host_interrupt_out_i,
  input  wire logic                clk_mode_wr_i,
  input  wire logic [2:0]          clk_mode_wdata_i,
  // device pins out
  output tcs_pkg::tcs_pin_t        timer_zero_pulse_out_o,
  output tcs_pkg::tcs_pin_t        timer_one_pulse_out_o,
  output tcs_pkg::tcs_pin_t        machine_clock_out_o,
  // core side out
  output logic [2:0]               clk_mode_o,
  output logic                     in_reset_o
);
  import tcs_pkg::*;

  logic [SYNC_W-1:0]  sync_level;
  logic [STRAP_W-1:0] strap_s;
  logic               dev_reset_n_s;
  logic               float_n_s;

  tcs_state_t         state_ff;
  tcs_state_t         nxt_state;
  logic [STRAP_W-1:0] mode_ff;
  logic [STRAP_W-1:0] nxt_mode;

  logic [PHASE_W-1:0] phase_ff;
  logic [PHASE_W-1:0] nxt_phase;
  logic               mcyc_start;

  logic               pend0_ff;
  logic               pend1_ff;
  logic               pulse0_ff;
  logic               pulse1_ff;
  logic               nxt_pend0;
  logic               nxt_pend1;
  logic               nxt_pulse0;
  logic               nxt_pulse1;

  tcs_pin_t           t0_ff;
  tcs_pin_t           t1_ff;
  tcs_pin_t           mclk_ff;
  tcs_pin_t           nxt_t0;
  tcs_pin_t           nxt_t1;
  tcs_pin_t           nxt_mclk;

  logic               timers_held;
  logic               in_reset_ff;
  logic               nxt_in_reset;

  // pin synchroniser for straps, device reset and float control
  tcs_pin_sync u_sync (
    .ref_clk_i (ref_clk_i),
    .rst_i     (rst_i),
    .raw_i     ({emu_float_ctl_n_i, dev_reset_n_i, clock_strap_i}),
    .level_o   (sync_level)
  );

  assign strap_s       = sync_level[SYNC_STRAP_LSB +: STRAP_W];
  assign dev_reset_n_s = sync_level[SYNC_RESET_BIT];
  assign float_n_s     = sync_level[SYNC_FLOAT_BIT];
  assign timers_held   = !dev_reset_n_s;

  // pulse stretcher: {pending, pulse} next value; hold_off clears both, even over a new underflow
  function automatic logic [1:0] pulse_step(
    input logic pend,
    input logic pulse,
    input logic uf,
    input logic start,
    input logic hold_off
  );
    logic [1:0] r;
    r = {pend | uf, pulse};
    if (hold_off) begin
      r = 2'h0;
    end else if (start) begin
      r = {1'b0, pend | uf};
    end
    return r;
  endfunction

  // reset tracking and clock mode register
  always_comb begin
    nxt_state = state_ff;
    nxt_mode  = mode_ff;
    case (state_ff)
      ST_IN_RESET: begin
        nxt_mode = strap_s; // [R1]
        if (dev_reset_n_s) begin
          nxt_state = ST_RUN;
        end
      end
      ST_RUN: begin
        if (!dev_reset_n_s) begin
          nxt_state = ST_IN_RESET;
          nxt_mode  = strap_s; // [R1]
        end else if (clk_mode_wr_i) begin
          nxt_mode = clk_mode_wdata_i; // [R2]
        end
      end
      default: begin
        nxt_state = ST_IN_RESET;
        nxt_mode  = CLK_MODE_RST;
      end
    endcase
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_ff <= ST_IN_RESET;
      mode_ff  <= CLK_MODE_RST;
    end else begin
      state_ff <= nxt_state;
      mode_ff  <= nxt_mode;
    end
  end

  // machine cycle phase and machine clock pin
  always_comb begin
    mcyc_start   = (phase_ff == PHASE_LAST);
    nxt_phase    = mcyc_start ? PHASE_FIRST : phase_ff + PHASE_STEP; // [R8]
    nxt_mclk.lvl = (nxt_phase < PHASE_HALF); // [R8]
    nxt_mclk.oe  = float_n_s;
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      phase_ff <= PHASE_FIRST;
      mclk_ff  <= PIN_RST;
    end else begin
      phase_ff <= nxt_phase;
      mclk_ff  <= nxt_mclk;
    end
  end

  // timer zero pulse, aligned to machine cycles
  // a pending underflow waits for the next machine cycle start
  always_comb begin
    {nxt_pend0, nxt_pulse0} = pulse_step(pend0_ff, pulse0_ff, tmr0_underflow_i,
                                         mcyc_start, timers_held); // [R3] [R4] [R9]
    nxt_t0.lvl = nxt_pulse0; // [R3]
    nxt_t0.oe  = float_n_s; // [R7]
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pend0_ff  <= 1'b0;
      pulse0_ff <= 1'b0;
      t0_ff     <= PIN_RST;
    end else begin
      pend0_ff  <= nxt_pend0;
      pulse0_ff <= nxt_pulse0;
      t0_ff     <= nxt_t0;
    end
  end

  // timer one pulse on the pin shared with the host interrupt
  always_comb begin
    {nxt_pend1, nxt_pulse1} = pulse_step(pend1_ff, pulse1_ff, tmr1_underflow_i,
                                         mcyc_start, timers_held); // [R5] [R9]
    if (host_port_en_i) begin
      nxt_t1.lvl = host_interrupt_out_i; // [R6]
    end else begin
      nxt_t1.lvl = nxt_pulse1; // [R6]
    end
    nxt_t1.oe  = float_n_s; // [R7]
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pend1_ff  <= 1'b0;
      pulse1_ff <= 1'b0;
      t1_ff     <= PIN_RST;
    end else begin
      pend1_ff  <= nxt_pend1;
      pulse1_ff <= nxt_pulse1;
      t1_ff     <= nxt_t1;
    end
  end

  // reset status flag, kept in its own register
  always_comb begin
    nxt_in_reset = (nxt_state == ST_IN_RESET);
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      in_reset_ff <= 1'h1;
    end else begin
      in_reset_ff <= nxt_in_reset;
    end
  end

  // pins and status straight from registers
  assign timer_zero_pulse_out_o = t0_ff;
  assign timer_one_pulse_out_o  = t1_ff;
  assign machine_clock_out_o    = mclk_ff;
  assign clk_mode_o             = mode_ff;
  assign in_reset_o             = in_reset_ff;

endmodule

// ===== tb/tb_tcs_timer_out.sv
`timescale 1ns/1ps
module tb_tcs_timer_out;
  import tcs_pkg::*;
  logic ref_clk_i = 0, rst_i = 1, dev_n = 0, emu_n = 1;
  logic uf0 = 0, uf1 = 0, hen = 0, host_irq = 0, wr = 0, inr;
  logic [2:0] wd = 0, sel = 5, mode;
  tcs_strap_t strap;
  tcs_pin_t p0, p1, pm;
  int failures = 0, n_compared = 0, cyc = 0;
  tcs_board_model i_board (.strap_sel_i(sel), .clock_strap_o(strap));
  tcs_timer_out i_dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .clock_strap_i(strap), .dev_reset_n_i(dev_n),
    .emu_float_ctl_n_i(emu_n), .tmr0_underflow_i(uf0), .tmr1_underflow_i(uf1), .host_port_en_i(hen),
    .host_interrupt_out_i(host_irq), .clk_mode_wr_i(wr), .clk_mode_wdata_i(wd), .timer_zero_pulse_out_o(p0),
    .timer_one_pulse_out_o(p1), .machine_clock_out_o(pm), .clk_mode_o(mode), .in_reset_o(inr));
  initial forever #5 ref_clk_i = ~ref_clk_i;
  task automatic tk(int n);
    repeat (n) @(negedge ref_clk_i);
  endtask
  task automatic chk(logic [7:0] seen, logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  always @(posedge ref_clk_i) begin
    cyc++;
    if (cyc == 1000) begin
      failures++;
      tally_and_finish();
    end
  end
  task automatic strap_scn;
    tk(10);
    chk(mode, 8'h5);
    chk(inr, 8'h1);
    sel = 3'h2;
    tk(10);
    chk(mode, 8'h2);
    dev_n = 1;
    tk(8);
    chk(inr, 8'h0);
    sel = 3'h7;
    tk(10);
    chk(mode, 8'h2);
    wd = 3'h6;
    wr = 1;
    tk(1);
    wr = 0;
    chk(mode, 8'h6);
  endtask
  task automatic pulse_scn(logic one);
    logic [7:0] hi;
    hi = 0;
    uf0 = !one;
    uf1 = one;
    tk(1);
    uf0 = 0;
    uf1 = 0;
    repeat (6) begin
      hi += one ? p1.lvl : p0.lvl;
      tk(1);
    end
    chk(hi, 8'h2);
  endtask
  initial begin
    tk(2);
    rst_i = 0;
    strap_scn();
    pulse_scn(0);
    pulse_scn(1);
    hen = 1;
    host_irq = 1;
    tk(3);
    chk(p1.lvl, 8'h1);
    host_irq = 0;
    uf1 = 1;
    tk(1);
    uf1 = 0;
    tk(3);
    chk(p1.lvl, 8'h0);
    emu_n = 0;
    tk(8);
    chk({p0.oe, p1.oe}, 8'h0);
    emu_n = 1;
    tk(8);
    chk({p0.oe, p1.oe, pm.oe}, 8'h7);
    tally_and_finish();
  end
endmodule

// ===== tb/tcs_board_model.sv
`timescale 1ns/1ps
module tcs_board_model
  import tcs_pkg::*;
(
  // jumper choice in, strap pins out
  input  wire logic [2:0]          strap_sel_i,
  output tcs_pkg::tcs_strap_t      clock_strap_o
);
  assign clock_strap_o = strap_sel_i;
endmodule

// ===== tb/tcs_timer_out_chk.sv
`timescale 1ns/1ps
module tcs_timer_out_chk
  import tcs_pkg::*;
(
  // clock and reset
  input wire logic                ref_clk_i,
  input wire logic                rst_i,
  // inputs
  input wire tcs_pkg::tcs_strap_t clock_strap_i,
  input wire logic                emu_float_ctl_n_i,
  input wire logic                tmr0_underflow_i,
  input wire logic                tmr1_underflow_i,
  input wire logic                host_port_en_i,
  input wire logic                host_interrupt_out_i,
  input wire logic                clk_mode_wr_i,
  input wire logic [2:0]          clk_mode_wdata_i,
  // outputs
  input wire tcs_pkg::tcs_pin_t   timer_zero_pulse_out_o,
  input wire tcs_pkg::tcs_pin_t   timer_one_pulse_out_o,
  input wire tcs_pkg::tcs_pin_t   machine_clock_out_o,
  input wire logic [2:0]          clk_mode_o,
  input wire logic                in_reset_o
);
  wire t0 = timer_zero_pulse_out_o.lvl;
  wire t1 = timer_one_pulse_out_o.lvl;
  wire mc = machine_clock_out_o.lvl;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  t0_pulse_a: assert property (tmr0_underflow_i && !in_reset_o |-> ##[1:2] (t0 && mc) ##1 t0 ##1 !t0)
    else $error("timer zero pulse wrong");
  t0_cause_a: assert property ($rose(t0) |-> $past(tmr0_underflow_i) || $past(tmr0_underflow_i, 2))
    else $error("timer zero pulse without underflow");
  t1_pulse_a: assert property (tmr1_underflow_i && !in_reset_o && !host_port_en_i |-> ##[1:2] (t1 && mc) ##1 t1 ##1 !t1)
    else $error("timer one pulse wrong");
  shared_pin_a: assert property (host_port_en_i && $past(host_port_en_i) |-> t1 == $past(host_interrupt_out_i))
    else $error("shared pin not host interrupt");
  mclk_rate_a: assert property (mc |=> !mc ##1 mc)
    else $error("machine clock rate wrong");
  pin_float_a: assert property (!emu_float_ctl_n_i[*6] |-> !timer_zero_pulse_out_o.oe && !timer_one_pulse_out_o.oe)
    else $error("timer pins still driven");
  strap_load_a: assert property ((in_reset_o && $stable(clock_strap_i))[*6] |-> clk_mode_o == clock_strap_i)
    else $error("clock mode not strap");
  mode_wr_a: assert property (clk_mode_wr_i && !in_reset_o ##1 !in_reset_o |-> clk_mode_o == $past(clk_mode_wdata_i))
    else $error("clock mode write lost");
endmodule
bind tcs_timer_out tcs_timer_out_chk i_chk (.*);
